// *** tpffp_top.sv ***
// triple port fifo: wide 36-bit port, 18-bit transmit and receive ports.
// assumes all three ports share I_CLK and drive inputs synchronous to it;
// the pad logic resolves the wide bus from O_WIDE_PORT_BUS_OE.
//
// Behaviour
// - wide port bus reads and writes
// - transmit bus outputs queue halves
// - receive bus inputs queue halves
// - wide almost-empty low at count at offset
// - transmit almost-empty low at count at offset
// - wide almost-full low at free at offset
// - receive almost-full low at free at offset
// - endian pin high: most significant first
// - endian pin low: least significant first
// - after reset pin picks timing mode
// - wide port transfers and flags on clock
// - transmit reads and flags on clock
// - receive writes and flags on clock
// - wide select low gates transfers, drive
// - transmit select low gates reads, drive
// - wide enable high needed for transfer
// - wide empty/ready flag by mode
// - transmit empty/ready flag by mode
// - wide full/ready flag same in both modes: high on space
// - receive full/ready flag same in both modes: high on space
// - fall-through shows first word unrequested
// - flags pass two-stage synchroniser
`timescale 1ns/100ps
module tpffp_top #(
    parameter int DEPTH = tpffp_pkg::QUEUE_DEPTH,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_ENDIAN_TIMING_SELECT,
    input wire logic I_WIDE_PORT_SELECT_N,
    input wire logic I_WIDE_PORT_ENABLE,
    input wire logic I_WIDE_PORT_WRITE,
    input wire logic [tpffp_pkg::WIDE_W-1:0] I_WIDE_PORT_BUS,
    output logic [tpffp_pkg::WIDE_W-1:0] O_WIDE_PORT_BUS,
    output logic O_WIDE_PORT_BUS_OE,
    output logic O_WIDE_PORT_EMPTY_OR_READY,
    output logic O_WIDE_PORT_FULL_OR_READY,
    output logic O_WIDE_PORT_ALMOST_EMPTY_N,
    output logic O_WIDE_PORT_ALMOST_FULL_N,
    input wire logic I_TX_PORT_SELECT_N,
    input wire logic I_TX_PORT_READ,
    output logic [tpffp_pkg::NARROW_W-1:0] O_TX_PORT_BUS,
    output logic O_TX_PORT_BUS_OE,
    output logic O_TX_PORT_EMPTY_OR_READY,
    output logic O_TX_PORT_ALMOST_EMPTY_N,
    input wire logic I_RX_PORT_WRITE,
    input wire logic [tpffp_pkg::NARROW_W-1:0] I_RX_PORT_BUS,
    output logic O_RX_PORT_FULL_OR_READY,
    output logic O_RX_PORT_ALMOST_FULL_N,
    input wire logic [CW-1:0] I_TX_ALMOST_EMPTY_OFFSET,
    input wire logic [CW-1:0] I_WIDE_ALMOST_EMPTY_OFFSET,
    input wire logic [CW-1:0] I_WIDE_ALMOST_FULL_OFFSET,
    input wire logic [CW-1:0] I_RX_ALMOST_FULL_OFFSET
);
    localparam int WW = tpffp_pkg::WIDE_W;
    localparam int NW = tpffp_pkg::NARROW_W;
    localparam int FW = tpffp_pkg::FLAG_W;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    if (DEPTH < 2 || CW != $clog2(DEPTH + 1) || WW != 2 * NW) begin : g_check
        $error("tpffp_top: depth below 2 or widths inconsistent");
    end

    // order of the two halves inside a wide word
    function automatic logic [NW-1:0] pick_half(input logic [WW-1:0] word,
                                                input logic big, input logic second);
        logic upper;
        upper = big ^ second;
        return upper ? word[WW-1:NW] : word[NW-1:0];
    endfunction : pick_half

    function automatic logic [WW-1:0] join_pair(input logic [NW-1:0] first,
                                                input logic [NW-1:0] second,
                                                input logic big);
        return big ? {first, second} : {second, first};
    endfunction : join_pair

    function automatic logic at_or_below(input logic [CW-1:0] value,
                                         input logic [CW-1:0] offset);
        return value <= offset;
    endfunction : at_or_below

    function automatic logic [CW-1:0] free_slots(input logic [CW-1:0] count);
        return DEPTH_C - count;
    endfunction : free_slots

    logic big_q;
    logic fall_through_q;
    logic taken_q;
    logic q1_push;
    logic q1_ready;
    logic q1_valid;
    logic q1_rd_ready;
    logic [WW-1:0] q1_rdata;
    logic [CW-1:0] q1_count;
    logic q2_push;
    logic q2_ready;
    logic q2_valid;
    logic [WW-1:0] q2_rdata;
    logic [CW-1:0] q2_count;
    logic wide_sel;
    logic wide_wr_req;
    logic wide_rd_req;
    logic wide_step;
    logic wide_or_q;
    logic tx_rd_req;
    logic tx_step;
    logic tx_avail;
    logic tx_pend_q;
    logic tx_sel_q;
    logic tx_or_q;
    logic rx_hold_q;
    logic [NW-1:0] rx_half_q;
    logic [FW-1:0] flag_raw;
    logic [FW-1:0] flag_s1_q;
    logic [FW-1:0] flag_s2_q;

    // endian is caught while reset is held, timing mode on the first
    // cycle after release; the pin is expected static from then on
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            big_q <= I_ENDIAN_TIMING_SELECT;
            taken_q <= 1'b0;
            fall_through_q <= 1'b0;
        end else if (!taken_q) begin
            taken_q <= 1'b1;
            fall_through_q <= !I_ENDIAN_TIMING_SELECT;
        end
    end

    // wide port: one request per edge, gated by select and enable
    assign wide_sel = !I_WIDE_PORT_SELECT_N && I_WIDE_PORT_ENABLE;
    assign wide_wr_req = wide_sel && I_WIDE_PORT_WRITE;
    assign wide_rd_req = wide_sel && !I_WIDE_PORT_WRITE;
    assign q1_push = wide_wr_req && q1_ready;
    // fall-through refills the output word whenever it is not shown
    assign wide_step = fall_through_q ? (!wide_or_q || wide_rd_req) : wide_rd_req;
    assign O_WIDE_PORT_BUS = q2_rdata;
    assign O_WIDE_PORT_BUS_OE = !I_WIDE_PORT_SELECT_N && !I_WIDE_PORT_WRITE;

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            wide_or_q <= 1'b0;
        end else if (fall_through_q && wide_step) begin
            wide_or_q <= q2_valid;
        end
    end

    // transmit port: each wide word leaves as two halves
    assign tx_rd_req = !I_TX_PORT_SELECT_N && I_TX_PORT_READ;
    assign tx_avail = tx_pend_q || q1_valid;
    assign tx_step = fall_through_q ? (!tx_or_q || tx_rd_req) : tx_rd_req;
    assign q1_rd_ready = tx_step && !tx_pend_q;
    assign O_TX_PORT_BUS = pick_half(q1_rdata, big_q, tx_sel_q);
    assign O_TX_PORT_BUS_OE = !I_TX_PORT_SELECT_N;

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            tx_pend_q <= 1'b0;
            tx_sel_q <= 1'b0;
        end else if (tx_step && tx_avail) begin
            if (tx_pend_q) begin
                tx_sel_q <= 1'b1;
                tx_pend_q <= 1'b0;
            end else begin
                tx_sel_q <= 1'b0;
                tx_pend_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            tx_or_q <= 1'b0;
        end else if (fall_through_q && tx_step) begin
            tx_or_q <= tx_avail;
        end
    end

    // receive port: first half is held, second half completes the word;
    // a second half that meets a full queue is dropped, hold stays
    assign q2_push = I_RX_PORT_WRITE && rx_hold_q && q2_ready;

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            rx_hold_q <= 1'b0;
            rx_half_q <= '0;
        end else if (I_RX_PORT_WRITE) begin
            if (!rx_hold_q) begin
                rx_half_q <= I_RX_PORT_BUS;
                rx_hold_q <= 1'b1;
            end else if (q2_ready) begin
                rx_hold_q <= 1'b0;
            end
        end
    end

    tpffp_fifo #(
        .WIDTH(WW),
        .DEPTH(DEPTH),
        .CW(CW)
    ) u_wide_to_tx_queue (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_wr_valid(q1_push),
        .o_wr_ready(q1_ready),
        .i_wr_data(I_WIDE_PORT_BUS),
        .o_rd_valid(q1_valid),
        .i_rd_ready(q1_rd_ready),
        .o_rd_data(q1_rdata),
        .o_count(q1_count)
    );

    tpffp_fifo #(
        .WIDTH(WW),
        .DEPTH(DEPTH),
        .CW(CW)
    ) u_rx_to_wide_queue (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_wr_valid(q2_push),
        .o_wr_ready(q2_ready),
        .i_wr_data(join_pair(rx_half_q, I_RX_PORT_BUS, big_q)),
        .o_rd_valid(q2_valid),
        .i_rd_ready(wide_step),
        .o_rd_data(q2_rdata),
        .o_count(q2_count)
    );

    // raw flags from the live counts, high meaning data or space
    always_comb begin
        flag_raw = '0;
        flag_raw[tpffp_pkg::F_WIDE_EOR] = fall_through_q ? wide_or_q : q2_valid;
        flag_raw[tpffp_pkg::F_TX_EOR] = fall_through_q ? tx_or_q : tx_avail;
        flag_raw[tpffp_pkg::F_WIDE_FIR] = q1_ready;
        flag_raw[tpffp_pkg::F_RX_FIR] = q2_ready;
        flag_raw[tpffp_pkg::F_WIDE_AE] =
            !at_or_below(q2_count, I_WIDE_ALMOST_EMPTY_OFFSET);
        flag_raw[tpffp_pkg::F_TX_AE] =
            !at_or_below(q1_count, I_TX_ALMOST_EMPTY_OFFSET);
        flag_raw[tpffp_pkg::F_WIDE_AF] =
            !at_or_below(free_slots(q1_count), I_WIDE_ALMOST_FULL_OFFSET);
        flag_raw[tpffp_pkg::F_RX_AF] =
            !at_or_below(free_slots(q2_count), I_RX_ALMOST_FULL_OFFSET);
    end

    // two stages keep the port view conservative: flags lag, the queue
    // logic itself never trusts them, so late flags cannot corrupt data
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            flag_s1_q <= tpffp_pkg::FLAG_RESET;
            flag_s2_q <= tpffp_pkg::FLAG_RESET;
        end else begin
            flag_s1_q <= flag_raw;
            flag_s2_q <= flag_s1_q;
        end
    end

    assign O_WIDE_PORT_EMPTY_OR_READY = flag_s2_q[tpffp_pkg::F_WIDE_EOR];
    assign O_TX_PORT_EMPTY_OR_READY = flag_s2_q[tpffp_pkg::F_TX_EOR];
    assign O_WIDE_PORT_FULL_OR_READY = flag_s2_q[tpffp_pkg::F_WIDE_FIR];
    assign O_RX_PORT_FULL_OR_READY = flag_s2_q[tpffp_pkg::F_RX_FIR];
    assign O_WIDE_PORT_ALMOST_EMPTY_N = flag_s2_q[tpffp_pkg::F_WIDE_AE];
    assign O_TX_PORT_ALMOST_EMPTY_N = flag_s2_q[tpffp_pkg::F_TX_AE];
    assign O_WIDE_PORT_ALMOST_FULL_N = flag_s2_q[tpffp_pkg::F_WIDE_AF];
    assign O_RX_PORT_ALMOST_FULL_N = flag_s2_q[tpffp_pkg::F_RX_AF];

    // helper: two clean cycles since reset before $past(.,2) is meaningful
    logic [1:0] live_q;
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            live_q <= 2'h0;
        end else begin
            live_q <= {live_q[0], 1'b1};
        end
    end

    wide_drive_off_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_WIDE_PORT_SELECT_N |-> !O_WIDE_PORT_BUS_OE)
        else $error("wide bus driven while deselected");

    tx_drive_off_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_TX_PORT_SELECT_N |-> !O_TX_PORT_BUS_OE)
        else $error("transmit bus driven while deselected");

    wide_no_xfer_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (!I_WIDE_PORT_ENABLE && !fall_through_q) |=> $stable(q1_count) || $past(q1_rd_ready))
        else $error("wide port transfer without enable");

    tx_no_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_TX_PORT_SELECT_N && !fall_through_q) |=> $stable(tx_pend_q) && $stable(tx_sel_q))
        else $error("transmit read while deselected");

    wide_ae_flag_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        live_q[1] |-> O_WIDE_PORT_ALMOST_EMPTY_N ==
            !($past(q2_count, 2) <= $past(I_WIDE_ALMOST_EMPTY_OFFSET, 2)))
        else $error("wide almost-empty flag wrong");

    tx_ae_flag_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        live_q[1] |-> O_TX_PORT_ALMOST_EMPTY_N ==
            !($past(q1_count, 2) <= $past(I_TX_ALMOST_EMPTY_OFFSET, 2)))
        else $error("transmit almost-empty flag wrong");

    wide_af_flag_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        live_q[1] |-> O_WIDE_PORT_ALMOST_FULL_N ==
            !((DEPTH_C - $past(q1_count, 2)) <= $past(I_WIDE_ALMOST_FULL_OFFSET, 2)))
        else $error("wide almost-full flag wrong");

    rx_af_flag_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        live_q[1] |-> O_RX_PORT_ALMOST_FULL_N ==
            !((DEPTH_C - $past(q2_count, 2)) <= $past(I_RX_ALMOST_FULL_OFFSET, 2)))
        else $error("receive almost-full flag wrong");

    flag_two_stage_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        live_q[1] |-> O_RX_PORT_FULL_OR_READY == $past(q2_ready, 2))
        else $error("receive full flag not two cycles behind");

    tx_first_half_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (q1_rd_ready && q1_valid) |=>
            O_TX_PORT_BUS == (big_q ? q1_rdata[WW-1:NW] : q1_rdata[NW-1:0]))
        else $error("transmit half order wrong");

    fall_through_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (fall_through_q && !tx_or_q && tx_avail) |=> tx_or_q)
        else $error("first word did not fall through");

    mode_pick_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(taken_q) |-> fall_through_q == !$past(I_ENDIAN_TIMING_SELECT))
        else $error("timing mode not taken from pin");

    // deselected in standard mode the receive queue may only grow
    wide_read_gate_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_WIDE_PORT_SELECT_N && !fall_through_q) |=> q2_count >= $past(q2_count))
        else $error("wide read while deselected");

    rx_full_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_RX_PORT_WRITE && rx_hold_q && !q2_ready) |=> rx_hold_q && q2_count <= $past(q2_count))
        else $error("receive half lost its hold at full");
endmodule : tpffp_top

// *** tpffp_pkg.sv ***
// constants shared by the triple port fifo: widths, depth, flag layout.
// assumes nothing of its surroundings; pure definitions.
package tpffp_pkg;
    localparam int WIDE_W = 36;
    localparam int NARROW_W = 18;
    localparam int QUEUE_DEPTH = 8;
    // flag vector layout before and after the two-stage synchroniser
    localparam int FLAG_W = 8;
    localparam int F_WIDE_EOR = 0;
    localparam int F_TX_EOR = 1;
    localparam int F_WIDE_FIR = 2;
    localparam int F_RX_FIR = 3;
    localparam int F_WIDE_AE = 4;
    localparam int F_TX_AE = 5;
    localparam int F_WIDE_AF = 6;
    localparam int F_RX_AF = 7;
    // empty queues: no data, space free, almost empty asserted (low)
    localparam logic [FLAG_W-1:0] FLAG_RESET = 8'hcc;
endpackage : tpffp_pkg

// *** tpffp_mem.sv ***
// small word memory with a registered read port.
// assumes a single clock and a synchronous active-high reset.
`timescale 1ns/100ps
module tpffp_mem #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic i_re,
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    if (DEPTH < 1 || AW < 1 || (2 ** AW) < DEPTH) begin : g_check
        $error("tpffp_mem: address width too small for depth");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] rdata_q;

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    // read data holds until the next read so outputs stay stable
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= '0;
        end else if (i_re) begin
            rdata_q <= mem_q[i_raddr];
        end
    end

    assign o_rdata = rdata_q;
endmodule : tpffp_mem

// *** tpffp_fifo.sv ***
// synchronous fifo, valid/ready on both sides, word count out.
// read data appear in a register one cycle after the pop.
// assumes one clock; pushing and popping in the same cycle is allowed.
`timescale 1ns/100ps
module tpffp_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8,
    parameter int CW = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data,
    output logic [CW-1:0] o_count
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    if (DEPTH < 2 || CW != $clog2(DEPTH + 1)) begin : g_check
        $error("tpffp_fifo: depth below 2 or count width wrong");
    end

    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic push;
    logic pop;

    // wrap by compare, so any depth works, not only powers of two
    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : next_ptr

    assign o_wr_ready = (count_q != DEPTH_C);
    assign o_rd_valid = (count_q != '0);
    assign push = i_wr_valid && o_wr_ready;
    assign pop = i_rd_ready && o_rd_valid;
    assign o_count = count_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= next_ptr(wr_ptr_q);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= next_ptr(rd_ptr_q);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count_q <= '0;
        end else if (push && !pop) begin
            count_q <= count_q + 1'b1;
        end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
        end
    end

    tpffp_mem #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_mem (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(push),
        .i_waddr(wr_ptr_q),
        .i_wdata(i_wr_data),
        .i_re(pop),
        .i_raddr(rd_ptr_q),
        .o_rdata(o_rd_data)
    );

    count_track_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (push && !pop) |=> (count_q == $past(count_q) + 1'b1))
        else $error("fifo count did not rise after a push");
endmodule : tpffp_fifo

// *** tpffp_rx_src.sv ***
// far-side model of the receive port: sends one wide word as two halves.
// assumes the block samples the receive bus on every rising edge of i_clk.
`timescale 1ns/100ps
module tpffp_rx_src (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic i_slow,
    input wire logic i_big,
    input wire logic [35:0] i_word,
    output logic o_write,
    output logic [17:0] o_bus,
    output logic o_busy
);
    logic [1:0] stage_q;
    logic [17:0] hold_q;
    assign o_busy = (stage_q != 2'h0);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stage_q <= 2'h0;
            o_write <= 1'b0;
            o_bus <= 18'h0;
            hold_q <= 18'h0;
        end else begin
            case (stage_q)
                2'h0: begin
                    if (i_go) begin
                        o_write <= 1'b1;
                        o_bus <= i_big ? i_word[35:18] : i_word[17:0];
                        hold_q <= i_big ? i_word[17:0] : i_word[35:18];
                        stage_q <= i_slow ? 2'h3 : 2'h1;
                    end else begin
                        // idle bus toggles so a stale half is never mistaken for data
                        o_bus <= ~o_bus;
                    end
                end
                2'h3: begin
                    o_write <= 1'b0;
                    o_bus <= ~o_bus;
                    stage_q <= 2'h1;
                end
                2'h1: begin
                    o_write <= 1'b1;
                    o_bus <= hold_q;
                    stage_q <= 2'h2;
                end
                default: begin
                    o_write <= 1'b0;
                    stage_q <= 2'h0;
                end
            endcase
        end
    end
endmodule : tpffp_rx_src

// *** tpffp_bench.sv ***
// self-checking bench for the triple port fifo, standard and fall-through modes.
// assumes the default depth of 8 words and 4-bit offset ports.
`timescale 1ns/100ps
module tpffp_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ets = 1'b1;
    logic wsel_n = 1'b1;
    logic wen = 1'b0;
    logic wwr = 1'b0;
    logic [35:0] wbus_i = 36'h0;
    logic tsel_n = 1'b1;
    logic trd = 1'b0;
    logic [3:0] tae = 4'h1;
    logic [3:0] wae = 4'h1;
    logic [3:0] waf = 4'h2;
    logic [3:0] raf = 4'h2;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic ff = 1'b0;
    logic [35:0] word = 36'h0;
    logic [35:0] wbus_o;
    logic [17:0] tbus;
    logic [17:0] rbus;
    logic woe, weor, wfir, waen, wafn, toe, teor, taen, rw, rfir, rafn, busy;
    int errors = 0;
    int total_checks = 0;

    always #12.5 clk = ~clk;

    tpffp_top dut (.I_CLK(clk), .I_RST(rst), .I_ENDIAN_TIMING_SELECT(ets),
        .I_WIDE_PORT_SELECT_N(wsel_n), .I_WIDE_PORT_ENABLE(wen), .I_WIDE_PORT_WRITE(wwr),
        .I_WIDE_PORT_BUS(wbus_i), .O_WIDE_PORT_BUS(wbus_o), .O_WIDE_PORT_BUS_OE(woe),
        .O_WIDE_PORT_EMPTY_OR_READY(weor), .O_WIDE_PORT_FULL_OR_READY(wfir),
        .O_WIDE_PORT_ALMOST_EMPTY_N(waen), .O_WIDE_PORT_ALMOST_FULL_N(wafn),
        .I_TX_PORT_SELECT_N(tsel_n), .I_TX_PORT_READ(trd), .O_TX_PORT_BUS(tbus),
        .O_TX_PORT_BUS_OE(toe), .O_TX_PORT_EMPTY_OR_READY(teor),
        .O_TX_PORT_ALMOST_EMPTY_N(taen), .I_RX_PORT_WRITE(rw), .I_RX_PORT_BUS(rbus),
        .O_RX_PORT_FULL_OR_READY(rfir), .O_RX_PORT_ALMOST_FULL_N(rafn),
        .I_TX_ALMOST_EMPTY_OFFSET(tae), .I_WIDE_ALMOST_EMPTY_OFFSET(wae),
        .I_WIDE_ALMOST_FULL_OFFSET(waf), .I_RX_ALMOST_FULL_OFFSET(raf));

    tpffp_rx_src rx_src (.i_clk(clk), .i_rst(rst), .i_go(go), .i_slow(slow), .i_big(ets),
        .i_word(word), .o_write(rw), .o_bus(rbus), .o_busy(busy));

    function automatic logic [35:0] dw(input int k);
        return {18'(k) ^ 18'h2a5a5, 18'(k) ^ 18'h15a5a};
    endfunction : dw

    function automatic logic [17:0] hf(input int k, input int i, input logic big);
        logic [35:0] w;
        w = dw(k);
        return ((i == 0) == big) ? w[35:18] : w[17:0];
    endfunction : hf

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic end_test(input string name);
        $display("test %s finished at %0t", name, $time);
    endtask : end_test

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic do_reset(input logic pin);
        @(posedge clk);
        rst <= 1'b1;
        ets <= pin;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        cyc(2);
    endtask : do_reset

    // n back-to-back wide transfers of words dw(first..); reads compared in standard mode
    task automatic wide_op(input logic wr, input logic en, input logic sel_n, input int first,
                           input int n);
        @(posedge clk);
        wsel_n <= sel_n;
        wen <= en;
        wwr <= wr;
        wbus_i <= dw(first);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            wbus_i <= dw(first + i + 1);
            if (i == n - 1) begin
                wsel_n <= 1'b1;
                wen <= 1'b0;
            end
            #1;
            chk(woe, (i < n - 1) && !sel_n && !wr);
            if (!wr && en && !ff) chk(wbus_o, dw(first + i));
        end
    endtask : wide_op

    task automatic tx_rd(input logic [17:0] exp);
        if (ff) chk(tbus, exp);
        @(posedge clk);
        tsel_n <= 1'b0;
        trd <= 1'b1;
        #1 chk(toe, 1'b1);
        @(posedge clk);
        trd <= 1'b0;
        tsel_n <= 1'b1;
        cyc(2);
        if (!ff) chk(tbus, exp);
    endtask : tx_rd

    task automatic rx_word(input logic [35:0] w, input logic s);
        @(posedge clk);
        go <= 1'b1;
        slow <= s;
        word <= w;
        @(posedge clk);
        go <= 1'b0;
        #1;
        while (busy) cyc(1);
    endtask : rx_word

    initial begin
        do_reset(1'b1);
        chk(weor, 1'b0);
        chk(wfir, 1'b1);
        chk(waen, 1'b0);
        chk(wafn, 1'b1);
        chk(teor, 1'b0);
        chk(taen, 1'b0);
        chk(rfir, 1'b1);
        chk(rafn, 1'b1);
        chk(toe, 1'b0);
        end_test("reset flags");
        wide_op(1'b1, 1'b0, 1'b0, 40, 1);
        wide_op(1'b1, 1'b1, 1'b1, 41, 1);
        cyc(3);
        chk(teor, 1'b0);
        wide_op(1'b1, 1'b1, 1'b0, 0, 9);
        cyc(3);
        chk(wfir, 1'b0);
        chk(wafn, 1'b0);
        chk(teor, 1'b1);
        chk(taen, 1'b1);
        end_test("wide fill");
        @(posedge clk);
        trd <= 1'b1;
        @(posedge clk);
        trd <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            tx_rd(hf(k / 2, k % 2, 1'b1));
            chk(taen, (8 - (k / 2 + 1)) > tae);
            chk(wafn, (k / 2 + 1) > waf);
        end
        chk(teor, 1'b0);
        end_test("tx drain");
        for (int k = 0; k < 9; k++) rx_word(dw(10 + k), k % 2 == 1);
        cyc(3);
        chk(rfir, 1'b0);
        chk(rafn, 1'b0);
        chk(weor, 1'b1);
        chk(waen, 1'b1);
        wide_op(1'b0, 1'b1, 1'b0, 10, 8);
        wide_op(1'b0, 1'b1, 1'b0, 17, 1);
        cyc(2);
        chk(weor, 1'b0);
        chk(waen, 1'b0);
        chk(rfir, 1'b1);
        chk(rafn, 1'b1);
        end_test("rx fill");
        do_reset(1'b0);
        ff = 1'b1;
        rx_word(dw(20), 1'b0);
        rx_word(dw(21), 1'b1);
        cyc(4);
        chk(wbus_o, dw(20));
        chk(weor, 1'b1);
        cyc(4);
        chk(wbus_o, dw(20));
        wide_op(1'b0, 1'b1, 1'b0, 20, 1);
        cyc(3);
        chk(wbus_o, dw(21));
        wide_op(1'b0, 1'b1, 1'b0, 21, 1);
        cyc(3);
        chk(weor, 1'b0);
        end_test("fall through wide");
        wide_op(1'b1, 1'b1, 1'b0, 30, 1);
        cyc(4);
        chk(teor, 1'b1);
        tx_rd(hf(30, 0, 1'b0));
        tx_rd(hf(30, 1, 1'b0));
        chk(teor, 1'b0);
        end_test("fall through tx");
        tally_and_finish();
    end

    initial begin
        // whole run needs well under a thousand cycles
        repeat (4000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule : tpffp_bench
